// >>> hdl/angle_converter_host_regs.sv
// Short I/O slave holding two angle words and the relay/lamp control
//
// What this block does
// - Respond only when A15..A3 match the base address switches.
// - Two angle registers; a write changes only its own channel.
// - Angle is 14-bit binary fraction of a turn; bit 13 is 180 deg.
// - Angle registers are write only; byte and word writes accepted.
// - Control bit 15 drives fail lamp; zero lights it.
// - Fail lamp is lit at power-up or system reset.
// - Reset clears every register bit, all relays drop.
// - Control bit 14 energizes channel 0 field relay.
// - Control bit 13 energizes channel 0 test bus relay.
// - Control bit 12 energizes channel 1 field relay.
// - Control bit 11 energizes channel 1 test bus relay.
// - Both test bus relays are never energized together.
// - The test relay set first keeps priority until released.
// - Answer short supervisory modifier; switch selects non-privileged.
// - Board occupies eight bytes of short I/O space.
`include "angle_map.svh"
`default_nettype none
module angle_converter_host_regs
  import angle_pkg::*;
  (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [15:1] A,
  input wire logic [5:0] AM,
  input wire logic AS_N,
  input wire logic DS0_N,
  input wire logic DS1_N,
  input wire logic LWORD_N,
  input wire logic WRITE_N,
  input wire logic [15:0] D_IN,
  output logic [15:0] D_OUT,
  output logic D_OE,
  output logic DTACK_N_OUT,
  output logic DTACK_OE,
  input wire logic [15:3] BASE_SWITCH,
  input wire logic USER_AM_SWITCH,
  output logic [13:0] CHAN0_ANGLE_BITS,
  output logic [13:0] CHAN1_ANGLE_BITS,
  output logic FAIL_LAMP_OFF,
  output logic FIELD_ROUTE_CHAN0,
  output logic TESTBUS_ROUTE_CHAN0,
  output logic FIELD_ROUTE_CHAN1,
  output logic TESTBUS_ROUTE_CHAN1
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation; address/data are read only after strobes settle
  logic [2:0] strb;
  logic as_s;
  logic ds0_s;
  logic ds1_s;

  pin_sync #(.WIDTH(3)) u_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .din({~AS_N, ~DS0_N, ~DS1_N}),
    .dout(strb)
  );
  assign as_s = strb[2];
  assign ds0_s = strb[1];
  assign ds1_s = strb[0];

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic am_ok;
  logic hit;
  logic any_ds;

  assign am_ok = USER_AM_SWITCH ? (AM == `AM_SHORT_USER)
                                : (AM == `AM_SHORT_SUPER);
  assign any_ds = ds0_s | ds1_s;
  assign hit = as_s & any_ds & am_ok & LWORD_N
               & (A[15:3] == BASE_SWITCH);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus state
  bus_state_e state;
  bus_state_e next_state;
  angle_t ang0;
  angle_t ang1;
  ctrl_s ctrl;
  angle_t next_ang0;
  angle_t next_ang1;
  ctrl_s next_ctrl;
  logic [15:0] next_d_out;
  logic [15:0] d_out_r;
  logic dt;
  logic next_dt;
  logic rd;
  logic next_rd;

  always_comb
  begin
    next_state = state;
    next_ang0 = ang0;
    next_ang1 = ang1;
    next_ctrl = ctrl;
    next_d_out = d_out_r;
    next_dt = dt;
    next_rd = rd;
    case (state)
      ST_IDLE:
      begin
        if (hit)
        begin
          next_state = ST_ACK;
          next_dt = 1'b1;
          next_rd = WRITE_N;
          next_d_out = 16'h0000;
          if (!WRITE_N)
          begin
            // Upper lane D15..D8 pairs with even offset
            if (A[2:1] == 2'b00)
            begin
              if (ds1_s) next_ang0[13:8] = D_IN[13:8];
              if (ds0_s) next_ang0[7:0] = D_IN[7:0];
            end
            else if (A[2:1] == 2'b01)
            begin
              if (ds1_s) next_ang1[13:8] = D_IN[13:8];
              if (ds0_s) next_ang1[7:0] = D_IN[7:0];
            end
            else if (A[2:1] == 2'b10 && ds1_s)
            begin
              next_ctrl.fail_lamp_off = D_IN[15];
              next_ctrl.field_route_chan0 = D_IN[14];
              next_ctrl.field_route_chan1 = D_IN[12];
              // First-set test relay locks out the other
              next_ctrl.testbus_route_chan0 = D_IN[13]
                & ~(ctrl.testbus_route_chan1 & D_IN[11]);
              next_ctrl.testbus_route_chan1 = D_IN[11]
                & ~(D_IN[13] & ~ctrl.testbus_route_chan1)
                & ~(ctrl.testbus_route_chan0 & D_IN[13]);
            end
          end
          else if (A[2:1] == 2'b10)
            next_d_out = {ctrl, 11'h000};
        end
      end
      ST_ACK:
      begin
        if (!any_ds)
        begin
          next_state = ST_IDLE;
          next_dt = 1'b0;
          next_rd = 1'b0;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state <= ST_IDLE;
      ang0 <= `ANGLE_RESET;
      ang1 <= `ANGLE_RESET;
      ctrl <= `CTRL_RESET;
      d_out_r <= 16'h0000;
      dt <= 1'b0;
      rd <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ang0 <= next_ang0;
      ang1 <= next_ang1;
      ctrl <= next_ctrl;
      d_out_r <= next_d_out;
      dt <= next_dt;
      rd <= next_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; DTACK is open collector style, driven low only
  assign D_OUT = d_out_r;
  assign D_OE = rd;
  assign DTACK_N_OUT = 1'b0;
  assign DTACK_OE = dt;
  assign CHAN0_ANGLE_BITS = ang0;
  assign CHAN1_ANGLE_BITS = ang1;
  assign FAIL_LAMP_OFF = ctrl.fail_lamp_off;
  assign FIELD_ROUTE_CHAN0 = ctrl.field_route_chan0;
  assign TESTBUS_ROUTE_CHAN0 = ctrl.testbus_route_chan0;
  assign FIELD_ROUTE_CHAN1 = ctrl.field_route_chan1;
  assign TESTBUS_ROUTE_CHAN1 = ctrl.testbus_route_chan1;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_test_excl;
    @(posedge CLK) disable iff (!RESETN)
      !(TESTBUS_ROUTE_CHAN0 && TESTBUS_ROUTE_CHAN1);
  endproperty
  a_test_excl: assert property (p_test_excl)
    else $error("both test relays energized");

  property p_prio0;
    @(posedge CLK) disable iff (!RESETN)
      TESTBUS_ROUTE_CHAN0 && state == ST_IDLE && hit && !WRITE_N
        && A[2:1] == 2'b10 && ds1_s && D_IN[13] |=> TESTBUS_ROUTE_CHAN0;
  endproperty
  a_prio0: assert property (p_prio0)
    else $error("held test relay lost priority");

  property p_no_hit;
    @(posedge CLK) disable iff (!RESETN)
      state == ST_IDLE && !hit |=> !DTACK_OE;
  endproperty
  a_no_hit: assert property (p_no_hit)
    else $error("acknowledged without address match");

  property p_lamp_wr;
    @(posedge CLK) disable iff (!RESETN)
      state == ST_IDLE && hit && !WRITE_N && A[2:1] == 2'b10 && ds1_s
        |=> FAIL_LAMP_OFF == $past(D_IN[15]);
  endproperty
  a_lamp_wr: assert property (p_lamp_wr)
    else $error("lamp bit not written");

  property p_ch1_keep;
    @(posedge CLK) disable iff (!RESETN)
      !(state == ST_IDLE && hit && !WRITE_N && A[2:1] == 2'b01)
        |=> $stable(CHAN1_ANGLE_BITS);
  endproperty
  a_ch1_keep: assert property (p_ch1_keep)
    else $error("channel 1 changed by other write");

  property p_ch0_low;
    @(posedge CLK) disable iff (!RESETN)
      state == ST_IDLE && hit && !WRITE_N && A[2:1] == 2'b00 && ds0_s
        |=> CHAN0_ANGLE_BITS[7:0] == $past(D_IN[7:0]);
  endproperty
  a_ch0_low: assert property (p_ch0_low)
    else $error("channel 0 low byte not written");

  property p_ch0_high;
    @(posedge CLK) disable iff (!RESETN)
      state == ST_IDLE && hit && !WRITE_N && A[2:1] == 2'b00 && ds1_s
        |=> CHAN0_ANGLE_BITS[13:8] == $past(D_IN[13:8]);
  endproperty
  a_ch0_high: assert property (p_ch0_high)
    else $error("channel 0 high bits not written");

  property p_read;
    @(posedge CLK) disable iff (!RESETN)
      state == ST_IDLE && hit && WRITE_N && A[2:1] == 2'b10
        |=> D_OE && D_OUT[10:0] == 11'h000 && D_OUT[15:11] == $past(ctrl);
  endproperty
  a_read: assert property (p_read)
    else $error("control read value wrong");

  property p_field;
    @(posedge CLK) disable iff (!RESETN)
      state == ST_IDLE && hit && !WRITE_N && A[2:1] == 2'b10 && ds1_s
        |=> FIELD_ROUTE_CHAN0 == $past(D_IN[14])
          && FIELD_ROUTE_CHAN1 == $past(D_IN[12]);
  endproperty
  a_field: assert property (p_field)
    else $error("field relay bits not written");

  sequence s_acking;
    state == ST_ACK && DTACK_OE;
  endsequence
  sequence s_strobes_gone;
    !any_ds;
  endsequence
  property p_ack_release;
    @(posedge CLK) disable iff (!RESETN)
      s_acking ##0 s_strobes_gone |=> !DTACK_OE && !D_OE;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge held after strobes released");
endmodule : angle_converter_host_regs
`default_nettype wire

// >>> hdl/angle_map.svh
// Register offsets, field positions and timing constants of the host regs
`ifndef ANGLE_MAP_SVH
`define ANGLE_MAP_SVH
`define OFS_CH0_HIGH 3'h0
`define OFS_CH0_LOW 3'h1
`define OFS_CH1_HIGH 3'h2
`define OFS_CH1_LOW 3'h3
`define OFS_CTRL_HIGH 3'h4
`define OFS_CTRL_LOW 3'h5
`define BIT_LAMP_OFF 4
`define BIT_FIELD0 3
`define BIT_TEST0 2
`define BIT_FIELD1 1
`define BIT_TEST1 0
`define CTRL_RESET 5'h00
`define ANGLE_RESET 14'h0000
`define AM_SHORT_SUPER 6'h2D
`define AM_SHORT_USER 6'h29
`define DTACK_HOLD_CYCLES 2
`endif

// >>> hdl/angle_pkg.sv
// Types shared by the angle converter host register files
`default_nettype none
package angle_pkg;
  typedef logic [13:0] angle_t;
  typedef struct packed {
    logic fail_lamp_off;
    logic field_route_chan0;
    logic testbus_route_chan0;
    logic field_route_chan1;
    logic testbus_route_chan1;
  } ctrl_s;
  typedef enum {ST_IDLE, ST_ACK, ST_WAIT} bus_state_e;
endpackage : angle_pkg
`default_nettype wire

// >>> hdl/pin_sync.sv
// Three-flop synchroniser for asynchronous bus pins
`default_nettype none
module pin_sync
  #(parameter int WIDTH = 1)
  (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
  );
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_dout;

  always_comb
  begin
    next_dout = dout;
    // Accept a change only when the two settled stages agree
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2[i] == s3[i])
        next_dout[i] = s2[i];
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : pin_sync
`default_nettype wire

// >>> verif/angle_converter_host_regs_test.sv
// Self-checking bench for the angle converter host registers
`include "angle_map.svh"
`default_nettype none
module angle_converter_host_regs_test;
  import angle_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:3] base = 13'h0A5;
  logic user_am = 1'b0;
  wire logic [15:1] a;
  wire logic [5:0] am;
  wire logic as_n, ds0_n, ds1_n, lword_n, write_n, d_oe, dt_n, dt_oe;
  wire logic [15:0] d_in, d_out;
  wire logic [13:0] ch0, ch1;
  wire logic [4:0] outs;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 65026;
  int i, k;
  angle_t exp0, exp1;
  logic [4:0] ctl;
  logic [15:0] rd, d;
  logic [1:0] ds;
  logic ack;
  logic [4:0] seq [6] = '{5'h04, 5'h05, 5'h01, 5'h05, 5'h00, 5'h05};
  always #2 clk = ~clk;
  angle_converter_host_regs u_dut (.CLK(clk), .RESETN(resetn), .A(a),
    .AM(am), .AS_N(as_n), .DS0_N(ds0_n), .DS1_N(ds1_n), .LWORD_N(lword_n),
    .WRITE_N(write_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe),
    .DTACK_N_OUT(dt_n), .DTACK_OE(dt_oe), .BASE_SWITCH(base),
    .USER_AM_SWITCH(user_am), .CHAN0_ANGLE_BITS(ch0),
    .CHAN1_ANGLE_BITS(ch1), .FAIL_LAMP_OFF(outs[4]),
    .FIELD_ROUTE_CHAN0(outs[3]), .TESTBUS_ROUTE_CHAN0(outs[2]),
    .FIELD_ROUTE_CHAN1(outs[1]), .TESTBUS_ROUTE_CHAN1(outs[0]));
  vme_host_model u_host (.CLK(clk), .A(a), .AM(am), .AS_N(as_n),
    .DS0_N(ds0_n), .DS1_N(ds1_n), .LWORD_N(lword_n), .WRITE_N(write_n),
    .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .DTACK_N_OUT(dt_n),
    .DTACK_OE(dt_oe));
  ////////////////////////////////////////////////////////////////////////
  function automatic angle_t merge(angle_t o, logic [1:0] s, logic [15:0] v);
    merge = o;
    if (s[1])
      merge[13:8] = v[13:8];
    if (s[0])
      merge[7:0] = v[7:0];
  endfunction : merge
  // First test relay set keeps it; chan0 wins a tie from idle
  function automatic logic [4:0] lock(logic [4:0] o, logic [4:0] r);
    lock = r;
    if (r[2] && r[0])
      lock[o[0] && !o[2] ? 2 : 0] = 1'b0;
  endfunction : lock
  task automatic check_word(string what, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      fail_count++;
    end
  endtask : check_word
  task automatic access(logic wr, logic [1:0] w, logic [5:0] m,
    logic [1:0] s, logic [15:0] v, logic eack, logic [15:3] b = base,
    logic lw = 1'b0);
    u_host.xfer(wr, {b, w}, m, s, lw, v, rd, ack);
    check_word("dtack", {15'h0000, eack}, {15'h0000, ack});
  endtask : access
  task automatic check_outs;
    check_word("angle0", {2'b00, exp0}, {2'b00, ch0});
    check_word("angle1", {2'b00, exp1}, {2'b00, ch1});
    check_word("outputs", {11'h000, ctl}, {11'h000, outs});
  endtask : check_outs
  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial
  begin
    exp0 = 14'h0000;
    exp1 = 14'h0000;
    ctl = 5'h00;
    base = 13'($random(seed));
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    check_outs();
    for (i = 0; i < 24; i++)
    begin
      k = $random(seed);
      d = 16'($random(seed));
      ds = (k[1:0] == 2'b00) ? 2'b11 : k[1:0];
      access(1'b1, {1'b0, k[2]}, `AM_SHORT_SUPER, ds, d, 1'b1);
      if (k[2])
        exp1 = merge(exp1, ds, d);
      else
        exp0 = merge(exp0, ds, d);
      check_outs();
    end
    access(1'b0, 2'b00, `AM_SHORT_SUPER, 2'b11, 16'h0000, 1'b1);
    check_word("angle_read", 16'h0000, rd);
    for (i = 0; i < 8; i++)
    begin
      ctl = {i[2], i[1], 1'b0, i[0], 1'b0};
      d = 16'($random(seed));
      access(1'b1, 2'b10, `AM_SHORT_SUPER, 2'b10,
        {ctl, d[10:0]}, 1'b1);
      check_outs();
      access(1'b0, 2'b10, `AM_SHORT_SUPER, 2'b11, 16'h0000, 1'b1);
      check_word("ctrl_read", {ctl, 11'h000}, rd);
    end
    for (i = 0; i < 6; i++)
    begin
      ctl = lock(ctl, seq[i]);
      access(1'b1, 2'b10, `AM_SHORT_SUPER, 2'b10,
        {seq[i], 11'h7FF}, 1'b1);
      check_outs();
    end
    access(1'b1, 2'b00, `AM_SHORT_SUPER, 2'b11, 16'h3FFF, 1'b0,
      base ^ 13'h0001);
    access(1'b1, 2'b00, `AM_SHORT_USER, 2'b11, 16'h3FFF, 1'b0);
    access(1'b1, 2'b11, `AM_SHORT_SUPER, 2'b11, 16'hFFFF, 1'b1);
    access(1'b1, 2'b10, `AM_SHORT_SUPER, 2'b01, 16'hFFFF, 1'b1);
    access(1'b1, 2'b00, `AM_SHORT_SUPER, 2'b11, 16'h3FFF, 1'b0, base,
      1'b1);
    check_outs();
    user_am = 1'b1;
    access(1'b1, 2'b01, `AM_SHORT_SUPER, 2'b11, 16'h1234, 1'b0);
    access(1'b1, 2'b01, `AM_SHORT_USER, 2'b11, 16'hC001, 1'b1);
    exp1 = 14'h0001;
    check_outs();
    resetn = 1'b0;
    exp0 = 14'h0000;
    exp1 = 14'h0000;
    ctl = 5'h00;
    @(negedge clk);
    check_outs();
    resetn = 1'b1;
    access(1'b1, 2'b00, `AM_SHORT_USER, 2'b11, 16'hC5A3, 1'b1);
    exp0 = 14'h05A3;
    check_outs();
    end_sim();
  end
endmodule : angle_converter_host_regs_test
`default_nettype wire

// >>> verif/vme_host_model.sv
// Bus master model issuing short I/O cycles to the host registers
`default_nettype none
module vme_host_model
  (
  input wire logic CLK,
  output logic [15:1] A,
  output logic [5:0] AM,
  output logic AS_N,
  output logic DS0_N,
  output logic DS1_N,
  output logic LWORD_N,
  output logic WRITE_N,
  output logic [15:0] D_IN,
  input wire logic [15:0] D_OUT,
  input wire logic D_OE,
  input wire logic DTACK_N_OUT,
  input wire logic DTACK_OE
  );
  timeunit 1ns;
  timeprecision 1ps;
  // Relays are ideal logic here, so drop-out pacing is not modelled
  initial
  begin
    A = 15'h7FFF;
    AM = 6'h00;
    AS_N = 1'b1;
    DS0_N = 1'b1;
    DS1_N = 1'b1;
    LWORD_N = 1'b1;
    WRITE_N = 1'b1;
    D_IN = 16'hA5A5;
  end
  // Called just after a falling edge; holds all until DTACK sampled or 16 clocks pass
  task automatic xfer(input logic wr, input logic [15:1] adr,
    input logic [5:0] mod, input logic [1:0] ds, input logic lw,
    input logic [15:0] wd, output logic [15:0] rd, output logic ack);
    int n;
    rd = 16'h0000;
    ack = 1'b0;
    A <= adr;
    AM <= mod;
    WRITE_N <= ~wr;
    LWORD_N <= ~lw;
    D_IN <= wd;
    AS_N <= 1'b0;
    DS1_N <= ~ds[1];
    DS0_N <= ~ds[0];
    for (n = 0; n < 16 && !ack; n++)
    begin
      @(posedge CLK);
      // Open-collector acknowledge counts only when driven low
      ack = (DTACK_OE === 1'b1 && DTACK_N_OUT === 1'b0);
      // Undriven data lines float up to the terminator level
      rd = (D_OE === 1'b1) ? D_OUT : 16'hFFFF;
    end
    @(negedge CLK);
    AS_N <= 1'b1;
    DS0_N <= 1'b1;
    DS1_N <= 1'b1;
    LWORD_N <= 1'b1;
    // Released lines show garbage, not the last value
    D_IN <= ~wd;
    A <= ~adr;
    // Strobes stay released long enough for the pin filter to see it
    for (n = 0; n < 16 && (n < 5 || DTACK_OE === 1'b1); n++)
      @(posedge CLK);
    if (DTACK_OE === 1'b1)
      ack = 1'b0;
    @(negedge CLK);
  endtask : xfer
endmodule : vme_host_model
`default_nettype wire
